/* verilog/iopdp_regs.sv */
/*
 * Port B/C direction and data registers, port 4/5 pull-up control,
 * behind a zero-wait AHB-Lite slave.
 * Assumes pins are external (synchronised here) and chip selects
 * arrive from logic on hclk.
 */
`default_nettype none
// Contract
// RULE_01 - Port B write-only direction, reset input
// RULE_02 - Port C write-only direction, CS or output
// RULE_03 - Port 4 read/write pull-up bits, reset off
// RULE_04 - Port 4 pull-up only while pin input
// RULE_05 - Port 5 pull-up only while pin input
// RULE_06 - Output pins drive data register, read/write
module iopdp_regs
    import iopdp_pkg::*;
#(
    parameter logic [7:0] CS_PIN_MASK = IOPDP_CS_MASK_DEFAULT
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    // Port B pins
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    // Port C pins and chip-select source
    input wire logic [7:0] port_c_in,
    input wire logic [7:0] chip_select_n,
    output logic [7:0] port_c_out,
    output logic [7:0] port_c_oe,
    // Port 4 and 5 direction and pull-up drive
    output logic [7:0] port_4_dir_bit,
    output logic [7:0] port_5_dir_bit,
    output logic [7:0] port_4_pullup_en,
    output logic [7:0] port_5_pullup_en
);
    logic [7:0] port_b_dir_bits;
    logic [7:0] port_c_dir_bits;
    logic [7:0] port_b_data_bits;
    logic [7:0] port_c_data_bits;
    logic [7:0] port_4_pullup_bits;
    logic [7:0] port_5_pullup_bits;
    logic [7:0] next_pb_dir;
    logic [7:0] next_pc_dir;
    logic [7:0] next_pb_data;
    logic [7:0] next_pc_data;
    logic [7:0] next_p4_pull;
    logic [7:0] next_p5_pull;
    logic [7:0] next_p4_dir;
    logic [7:0] next_p5_dir;
    logic wr_pend;
    logic next_wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] next_wr_idx;
    logic [31:0] next_hrdata;
    logic [7:0] port_b_sync;
    logic [7:0] port_c_sync;
    logic addr_phase;
    logic [7:0] acc_idx;
    logic [7:0] wbyte;
    logic [7:0] cs_sel;

    assign hreadyout = 1'b1;
    assign hresp = IOPDP_HRESP_OKAY;
    assign addr_phase = hsel && hready && htrans[1];
    assign acc_idx = haddr[9:2];
    assign wbyte = hwdata[7:0];
    // CS function only on masked pins set as output
    assign cs_sel = CS_PIN_MASK & port_c_dir_bits; // RULE_02

    // Bus phase tracking
    always_comb begin
        next_wr_pend = addr_phase && hwrite && (haddr[31:10] == '0);
        next_wr_idx = addr_phase ? acc_idx : wr_idx;
    end

    // Register writes land in the data phase
    always_comb begin
        next_pb_dir = port_b_dir_bits;
        next_pc_dir = port_c_dir_bits;
        next_pb_data = port_b_data_bits;
        next_pc_data = port_c_data_bits;
        next_p4_pull = port_4_pullup_bits;
        next_p5_pull = port_5_pullup_bits;
        next_p4_dir = port_4_dir_bit;
        next_p5_dir = port_5_dir_bit;
        if (wr_pend) begin
            case (wr_idx)
                IOPDP_IDX_PB_DIR: next_pb_dir = wbyte; // RULE_01
                IOPDP_IDX_PC_DIR: next_pc_dir = wbyte; // RULE_02
                IOPDP_IDX_PB_DATA: next_pb_data = wbyte; // RULE_06
                IOPDP_IDX_PC_DATA: next_pc_data = wbyte; // RULE_06
                IOPDP_IDX_P4_PULL: next_p4_pull = wbyte; // RULE_03
                IOPDP_IDX_P5_PULL: next_p5_pull = wbyte; // RULE_05
                IOPDP_IDX_P4_DIR: next_p4_dir = wbyte;
                IOPDP_IDX_P5_DIR: next_p5_dir = wbyte;
                default: begin
                end
            endcase
        end
    end

    // Read data registered at the address phase, held otherwise
    always_comb begin
        next_hrdata = hrdata;
        if (addr_phase && !hwrite) begin
            next_hrdata = IOPDP_RDATA_NONE;
            if (haddr[31:10] == '0) begin
                case (acc_idx)
                    // Input pins show the pin, output pins the register
                    IOPDP_IDX_PB_DATA: next_hrdata[7:0] =
                        (port_b_dir_bits & port_b_data_bits) |
                        (~port_b_dir_bits & port_b_sync); // RULE_06
                    IOPDP_IDX_PC_DATA: next_hrdata[7:0] =
                        (port_c_dir_bits & port_c_data_bits) |
                        (~port_c_dir_bits & port_c_sync); // RULE_06
                    IOPDP_IDX_P4_PULL:
                        next_hrdata[7:0] = port_4_pullup_bits; // RULE_03
                    IOPDP_IDX_P5_PULL:
                        next_hrdata[7:0] = port_5_pullup_bits; // RULE_05
                    // Direction registers are write-only and read zero
                    default: next_hrdata = IOPDP_RDATA_NONE;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_b_dir_bits <= IOPDP_RESET_BYTE; // RULE_01
            port_c_dir_bits <= IOPDP_RESET_BYTE; // RULE_02
            port_b_data_bits <= IOPDP_RESET_BYTE; // RULE_06
            port_c_data_bits <= IOPDP_RESET_BYTE;
            port_4_pullup_bits <= IOPDP_RESET_BYTE; // RULE_03
            port_5_pullup_bits <= IOPDP_RESET_BYTE; // RULE_05
            port_4_dir_bit <= IOPDP_RESET_BYTE;
            port_5_dir_bit <= IOPDP_RESET_BYTE;
            wr_pend <= 1'b0;
            wr_idx <= '0;
            hrdata <= IOPDP_RDATA_NONE;
        end else begin
            port_b_dir_bits <= next_pb_dir;
            port_c_dir_bits <= next_pc_dir;
            port_b_data_bits <= next_pb_data;
            port_c_data_bits <= next_pc_data;
            port_4_pullup_bits <= next_p4_pull;
            port_5_pullup_bits <= next_p5_pull;
            port_4_dir_bit <= next_p4_dir;
            port_5_dir_bit <= next_p5_dir;
            wr_pend <= next_wr_pend;
            wr_idx <= next_wr_idx;
            hrdata <= next_hrdata;
        end
    end

    // Pull-ups forced off on output pins
    assign port_4_pullup_en = port_4_pullup_bits & ~port_4_dir_bit; // RULE_04
    assign port_5_pullup_en = port_5_pullup_bits & ~port_5_dir_bit; // RULE_05

    iopdp_port #(
        .WIDTH(IOPDP_PORT_W)
    ) u_port_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .dir(port_b_dir_bits),
        .data(port_b_data_bits),
        .alt_sel(8'h00),
        .alt_val(8'h00),
        .pin_in(port_b_in),
        .pin_out(port_b_out),
        .pin_oe(port_b_oe),
        .pin_sync(port_b_sync)
    );

    iopdp_port #(
        .WIDTH(IOPDP_PORT_W)
    ) u_port_c (
        .hclk(hclk),
        .hresetn(hresetn),
        .dir(port_c_dir_bits),
        .data(port_c_data_bits),
        .alt_sel(cs_sel),
        .alt_val(chip_select_n),
        .pin_in(port_c_in),
        .pin_out(port_c_out),
        .pin_oe(port_c_oe),
        .pin_sync(port_c_sync)
    );

    // Helpers for the checks below
    logic wr_pb_dir;
    logic wr_pc_dir;
    logic wr_p4_pull;
    assign wr_pb_dir = wr_pend && (wr_idx == IOPDP_IDX_PB_DIR);
    assign wr_pc_dir = wr_pend && (wr_idx == IOPDP_IDX_PC_DIR);
    assign wr_p4_pull = wr_pend && (wr_idx == IOPDP_IDX_P4_PULL);

    property p_pb_dir_write;
        @(posedge hclk) disable iff (!hresetn)
        wr_pb_dir |=> port_b_oe == $past(hwdata[7:0]);
    endproperty
    a_pb_dir_write: assert property (p_pb_dir_write) // RULE_01
        else $error("port B enable does not follow direction write");

    property p_pb_dir_reads_zero;
        @(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite && haddr[31:2] == {22'h0, IOPDP_IDX_PB_DIR})
        |=> hrdata == IOPDP_RDATA_NONE;
    endproperty
    a_pb_dir_reads_zero: assert property (p_pb_dir_reads_zero) // RULE_01
        else $error("port B direction read returned nonzero");

    property p_pc_cs_drive;
        @(posedge hclk) disable iff (!hresetn)
        wr_pc_dir |=> port_c_oe == $past(hwdata[7:0]) &&
        ((port_c_out ^ chip_select_n) & port_c_oe & CS_PIN_MASK) == 8'h00;
    endproperty
    a_pc_cs_drive: assert property (p_pc_cs_drive) // RULE_02
        else $error("port C chip-select pin not driving select");

    property p_p4_pull_store;
        @(posedge hclk) disable iff (!hresetn)
        wr_p4_pull ##1 (!addr_phase || hwrite) [*2]
        |-> port_4_pullup_bits == $past(hwdata[7:0], 2);
    endproperty
    a_p4_pull_store: assert property (p_p4_pull_store) // RULE_03
        else $error("port 4 pull-up bits lost written value");

    property p_p4_off_when_out;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_idx == IOPDP_IDX_P4_DIR)
        |=> port_4_dir_bit == $past(hwdata[7:0]) &&
        (port_4_pullup_en & port_4_dir_bit) == 8'h00;
    endproperty
    a_p4_off_when_out: assert property (p_p4_off_when_out) // RULE_04
        else $error("port 4 pull-up on for output pin");

    property p_p5_pull_gate;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_idx == IOPDP_IDX_P5_DIR)
        |=> port_5_pullup_en == (port_5_pullup_bits & ~$past(hwdata[7:0]));
    endproperty
    a_p5_pull_gate: assert property (p_p5_pull_gate) // RULE_05
        else $error("port 5 pull-up not gated by direction");

    property p_pb_out_data;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_idx == IOPDP_IDX_PB_DATA)
        |=> port_b_out == $past(hwdata[7:0]);
    endproperty
    a_pb_out_data: assert property (p_pb_out_data) // RULE_06
        else $error("port B output does not show data write");

    property p_pc_data_out;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_idx == IOPDP_IDX_PC_DATA)
        |=> ((port_c_out ^ $past(hwdata[7:0])) & ~cs_sel) == 8'h00;
    endproperty
    a_pc_data_out: assert property (p_pc_data_out) // RULE_06
        else $error("port C generic output does not show data write");

    property p_pc_dir_reads_zero;
        @(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite && haddr[31:2] == {22'h0, IOPDP_IDX_PC_DIR})
        |=> hrdata == IOPDP_RDATA_NONE;
    endproperty
    a_pc_dir_reads_zero: assert property (p_pc_dir_reads_zero) // RULE_02
        else $error("port C direction read returned nonzero");

    property p_p4_pull_read;
        @(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite && haddr[31:2] == {22'h0, IOPDP_IDX_P4_PULL})
        |=> hrdata == {24'h0, $past(port_4_pullup_bits)};
    endproperty
    a_p4_pull_read: assert property (p_p4_pull_read) // RULE_03
        else $error("port 4 pull-up read does not show register");

    property p_p5_pull_store;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend && wr_idx == IOPDP_IDX_P5_PULL)
        |=> port_5_pullup_bits == $past(hwdata[7:0]);
    endproperty
    a_p5_pull_store: assert property (p_p5_pull_store) // RULE_05
        else $error("port 5 pull-up bits do not take written value");

    c_pb_dir_write: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_pb_dir ##1 port_b_oe != 8'h00);
    c_pc_cs_active: cover property (@(posedge hclk) disable iff (!hresetn)
        cs_sel != 8'h00);
    c_p4_pullup_on: cover property (@(posedge hclk) disable iff (!hresetn)
        port_4_pullup_en != 8'h00);
    c_p5_pullup_on: cover property (@(posedge hclk) disable iff (!hresetn)
        port_5_pullup_en != 8'h00);
    c_read_back: cover property (@(posedge hclk) disable iff (!hresetn)
        addr_phase && !hwrite ##1 hrdata != IOPDP_RDATA_NONE);
endmodule
`default_nettype wire

/* include/iopdp_pkg.sv */
/*
 * Constants for the port direction, data and pull-up register block:
 * register indices, reset values and default chip-select pin mask.
 * Assumes one 32-bit AHB-Lite slave where byte address = 4 * index.
 */
`default_nettype none
package iopdp_pkg;
    localparam int IOPDP_PORT_W = 8;
    localparam int IOPDP_IDX_W = 8;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IOPDP_IDX_PB_DIR = 8'hD4;
    localparam logic [7:0] IOPDP_IDX_PC_DIR = 8'hD5;
    localparam logic [7:0] IOPDP_IDX_PB_DATA = 8'hD6;
    localparam logic [7:0] IOPDP_IDX_PC_DATA = 8'hD7;
    localparam logic [7:0] IOPDP_IDX_P4_PULL = 8'hDA;
    localparam logic [7:0] IOPDP_IDX_P5_PULL = 8'hDB;
    localparam logic [7:0] IOPDP_IDX_P4_DIR = 8'hDC;
    localparam logic [7:0] IOPDP_IDX_P5_DIR = 8'hDD;
    localparam logic [7:0] IOPDP_RESET_BYTE = 8'h00;
    localparam logic [31:0] IOPDP_RDATA_NONE = 32'h0000_0000;
    localparam logic [7:0] IOPDP_CS_MASK_DEFAULT = 8'hF0;
    localparam logic [1:0] IOPDP_HTRANS_IDLE = 2'h0;
    localparam logic [1:0] IOPDP_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] IOPDP_HRESP_OKAY = 2'h0;
endpackage
`default_nettype wire

/* verilog/iopdp_port.sv */
/*
 * One port of pins: two-stage input synchroniser and output drive
 * selecting between the data register and an alternate function.
 * Assumes dir, data and alternate inputs come from hclk flip-flops.
 */
`default_nettype none
module iopdp_port
    import iopdp_pkg::*;
#(
    parameter int WIDTH = IOPDP_PORT_W
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control from registers
    input wire logic [WIDTH-1:0] dir,
    input wire logic [WIDTH-1:0] data,
    input wire logic [WIDTH-1:0] alt_sel,
    input wire logic [WIDTH-1:0] alt_val,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    // Synchronised pin level
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("iopdp_port: WIDTH must be 1 to 32");
    end

    always_comb begin
        next_meta = pin_in;
        next_sync = meta;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= '0;
            pin_sync <= '0;
        end else begin
            meta <= next_meta;
            pin_sync <= next_sync;
        end
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        // Alternate function only overrides the value, never the enable
        assign pin_out[i] = alt_sel[i] ? alt_val[i] : data[i];
        assign pin_oe[i] = dir[i];
    end
endmodule
`default_nettype wire

/* tb/iopdp_pins_model.sv */
/*
 * Board-side model of the port B and C pins.
 * Assumes the board drives every pin that the block leaves undriven.
 */
`default_nettype none
module iopdp_pins_model (
    // Drive from the block
    input wire logic [7:0] b_oe,
    input wire logic [7:0] b_out,
    input wire logic [7:0] c_oe,
    input wire logic [7:0] c_out,
    // Board levels
    input wire logic [7:0] b_board,
    input wire logic [7:0] c_board,
    // Resolved pin levels
    output logic [7:0] b_pin,
    output logic [7:0] c_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pins show the board, never the last driven value
    assign b_pin = (b_oe & b_out) | (~b_oe & b_board);
    assign c_pin = (c_oe & c_out) | (~c_oe & c_board);
endmodule
`default_nettype wire

/* tb/testbench.sv */
/*
 * Self-checking bench for the port register block over AHB-Lite.
 * Assumes zero-wait slave and 2-stage pin synchronisers.
 */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import iopdp_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = IOPDP_HTRANS_IDLE, hresp;
    logic [2:0] hsize = 3'h2;
    wire logic hready;
    logic [7:0] b_out, b_oe, c_out, c_oe, d4, d5, pu4, pu5, b_pin, c_pin;
    logic [7:0] b_board = 8'hA5, c_board = 8'h3C, cs_n = 8'h00;
    logic [7:0] idx [8] = '{IOPDP_IDX_PB_DIR, IOPDP_IDX_PC_DIR,
        IOPDP_IDX_PB_DATA, IOPDP_IDX_PC_DATA, IOPDP_IDX_P4_PULL,
        IOPDP_IDX_P5_PULL, IOPDP_IDX_P4_DIR, IOPDP_IDX_P5_DIR};
    logic [7:0] v [8], e [8];
    int mismatches = 0, n_tests = 0, cyc = 0;
    always #2 hclk = ~hclk;
    iopdp_regs iopdp_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(rd), .port_b_in(b_pin),
        .port_b_out(b_out), .port_b_oe(b_oe), .port_c_in(c_pin),
        .chip_select_n(cs_n), .port_c_out(c_out), .port_c_oe(c_oe),
        .port_4_dir_bit(d4), .port_5_dir_bit(d5),
        .port_4_pullup_en(pu4), .port_5_pullup_en(pu5));
    iopdp_pins_model iopdp_pins_model_i (.b_oe(b_oe), .b_out(b_out),
        .c_oe(c_oe), .c_out(c_out), .b_board(b_board),
        .c_board(c_board), .b_pin(b_pin), .c_pin(c_pin));
    function automatic logic [7:0] rd_exp(logic [7:0] d, q, p);
        return (d & q) | (~d & p);
    endfunction
    task automatic wrap_up();
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One single AHB transfer; master waits for hready at each phase
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= IOPDP_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= IOPDP_HTRANS_IDLE;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        r = rd;
        chk(32'(hresp), 32'(IOPDP_HRESP_OKAY));
    endtask
    task automatic rd_all();
        logic [31:0] r;
        for (int k = 0; k < 8; k++) begin
            ahb(1'b0, {22'h0, idx[k], 2'b00}, 32'h0, r);
            chk(r, {24'h0, e[k]});
        end
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk({b_oe, c_oe, b_out, c_out}, 32'h0);
        chk({16'h0, pu4, pu5}, 32'h0);
        @(posedge hclk);
        e = '{8'h00, 8'h00, b_board, c_board, 8'h00, 8'h00, 8'h00, 8'h00};
        rd_all();
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc > 30000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        logic [31:0] r;
        logic [7:0] c_exp;
        void'($urandom(92478));
        do_reset();
        for (int i = 0; i < 60; i++) begin
            // First passes are all-ones and all-zeros corners
            for (int k = 0; k < 8; k++) begin
                v[k] = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            end
            b_board <= 8'($urandom);
            c_board <= 8'($urandom);
            cs_n <= 8'($urandom);
            for (int k = 0; k < 8; k++) begin
                ahb(1'b1, {22'h0, idx[k], 2'b00}, {24'($urandom), v[k]}, r);
            end
            @(negedge hclk);
            c_exp = rd_exp(v[1] & IOPDP_CS_MASK_DEFAULT, cs_n, v[3]);
            chk(32'({b_oe, b_out}), 32'({v[0], v[2]}));
            chk(32'(c_oe), 32'(v[1]));
            chk(32'(c_out), 32'(c_exp));
            chk(32'({d4, d5}), 32'({v[6], v[7]}));
            chk(32'(pu4), 32'(v[4] & ~v[6]));
            chk(32'(pu5), 32'(v[5] & ~v[7]));
            repeat (3) @(posedge hclk);
            e = '{8'h00, 8'h00, rd_exp(v[0], v[2], b_board),
                rd_exp(v[1], v[3], c_board), v[4], v[5], 8'h00, 8'h00};
            rd_all();
        end
        // Unmapped index and nonzero upper address are ignored
        ahb(1'b1, {22'h0, 8'hD8, 2'b00}, 32'hFF, r);
        ahb(1'b1, {22'h1, IOPDP_IDX_P4_PULL, 2'b00}, 32'h5A, r);
        ahb(1'b0, {22'h0, 8'hD8, 2'b00}, 32'h0, r);
        chk(r, IOPDP_RDATA_NONE);
        rd_all();
        do_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
